// File: ddoc_pkg.sv
// Constants shared by the door driver output control block.
// Assumes a 40 MHz core clock and 16-bit control words addressed by a 5-bit index.
package ddoc_pkg;
	localparam int CLK_MHZ = 40;
	localparam int NCH = 12;
	localparam int NHB = 6;
	localparam int NLAMP = 5;

	localparam logic [4:0] ADDR_LAMP_MIRROR = 5'h01;
	localparam logic [4:0] ADDR_RECOV_PWM = 5'h02;
	localparam logic [15:0] LAMP_MIRROR_RESET = 16'h0000;
	localparam logic [15:0] RECOV_PWM_RESET = 16'h0000;
	localparam logic [15:0] LAMP_MIRROR_WMASK = 16'hfffe;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// lamp_and_mirror_control fields
	localparam int L7_HI = 15;
	localparam int L7_LO = 14;
	localparam int L8_HI = 13;
	localparam int L8_LO = 12;
	localparam int L9_EN = 11;
	localparam int L10_EN = 10;
	localparam int L11_EN = 9;
	localparam int PD_EN = 8;
	localparam int REF_MSB = 7;
	localparam int REF_LSB = 2;
	localparam int MIRROR_EN = 1;

	// recovery_and_pwm_select fields
	localparam int RECOV_HB1 = 15;
	localparam int RECOV_PD = 9;
	localparam int PULSE_GEN_EN = 8;
	localparam int HB1_PWM_SEL = 7;
	localparam int PD_PWM = 1;
	localparam int FULL_SCALE_SEL = 0;

	// Channel map: 0..5 half-bridges 1..6, 6 feedback pull-down, 7..11 lamps 7..11
	localparam int CH_PD = 6;
	localparam int CH_LAMP0 = 7;
	localparam int HB_ON_PIN_B = 4;
	localparam int LAMP_D = 3;

	// 1.2 V at 1.5/64 V per step is 51.2 steps, so the last code that fits is 51
	localparam logic [5:0] REF_CLAMP = 6'h33;
	localparam logic [5:0] REF_ZERO = 6'h00;
endpackage

// File: ddoc_pwm_if.sv
// Link between the control logic and the internal pulse generator.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface ddoc_pwm_if;
	logic enable;
	logic level;
	modport gen (input enable, output level);
	modport user (output enable, input level);
endinterface

// File: ddoc_pwm_gen.sv
// Internal pulse generator for the lamp outputs.
// Assumes duty is a static setting; period is a module parameter.
`timescale 1ns/1ps
module ddoc_pwm_gen
#(
	parameter int CNT_W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [CNT_W-1:0] duty,
	ddoc_pwm_if.gen pg
);
	logic [CNT_W-1:0] cnt_r;
	logic level_r;

	// Stopped and low while disabled so a lamp never sees a stale phase
	always_ff @(posedge clk)
	begin
		if (rst || !pg.enable)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst || !pg.enable)
			level_r <= 1'b0;
		else
			level_r <= (cnt_r < duty);
	end

	assign pg.level = level_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	gen_off_low_a: assert property (!pg.enable |=> !pg.level) else $error("pulse gen high while disabled");
	gen_runs_c: cover property (pg.enable && pg.level);
endmodule

// File: ddoc_top.sv
// Control words and output gating for lamp, half-bridge and mirror drivers.
// Assumes the serial frame decoder supplies single-cycle word writes and a held read address.
// Contract
// - Lamps 7 and 8 decode a two-bit field (01 low current, 10 high current, else off); lamps 9 to 11 use one bit.
// - An enabled lamp with its pulse select set is driven only while its selected pulse source is high.
// - The mirror feedback pull-down may switch on only while the reference code is zero.
// - With its pulse gate bit set the pull-down is on only while external pulse input A is high.
// - The mirror controller enable drives the pass gate and forces lamp 10 on.
// - The reference code is clamped to the 1.2 V code unless full scale is selected.
// - An overcurrent event sets the output flag and the global fault and switches the output off.
// - With recovery enabled a tripped output comes back after a programmable delay, otherwise it stays off until its flag is cleared.
// - Three pulse sources exist; the internal one runs and is usable by lamps only while enabled.
// - A half-bridge with pulse select set is on only while its pin is high; output 5 uses pin B, others pin A.
// - High and low switch of a half-bridge are never on together.
// - Leaving active mode clears the control words and turns every output off.
`timescale 1ns/1ps
module ddoc_top
	import ddoc_pkg::*;
#(
	parameter int RECOV_SHORT_US = 16,
	parameter int RECOV_LONG_US = 32,
	parameter int CNT_W = 12,
	parameter int DUTY_W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mode_active,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [NHB-1:0] hb_high_req,
	input wire logic [NHB-1:0] hb_low_req,
	input wire logic [NLAMP-1:0] lamp_ocr_en,
	input wire logic [NLAMP-1:0] lamp_pwm_sel,
	input wire logic recovery_delay_select,
	input wire logic ext_pulse_in_a,
	input wire logic ext_pulse_in_b,
	input wire logic [DUTY_W-1:0] pulse_gen_duty,
	input wire logic [NCH-1:0] oc_event,
	input wire logic [NCH-1:0] oc_flag_clear,
	output logic [NHB-1:0] hb_high_on,
	output logic [NHB-1:0] hb_low_on,
	output logic [NLAMP-1:0] lamp_on,
	output logic [1:0] lamp_high_current,
	output logic mirror_pass_gate_drive,
	output logic mirror_feedback_pulldown_on,
	output logic [5:0] mirror_ref_code,
	output logic [NCH-1:0] output_overcurrent_flag,
	output logic global_supply_current_fault
);
	localparam int RECOV_SHORT_CYC = RECOV_SHORT_US * CLK_MHZ;
	localparam int RECOV_LONG_CYC = RECOV_LONG_US * CLK_MHZ;

	// Returns {enabled, high_current} for a two-bit lamp field
	function automatic logic [1:0] lamp_decode(input logic hi, input logic lo);
		lamp_decode = {hi ^ lo, hi & ~lo};
	endfunction

	// Pulse gating: a cleared select lets the enable through unchanged
	function automatic logic pulse_gate(input logic sel, input logic src);
		pulse_gate = !sel || src;
	endfunction

	logic [15:0] lamp_mirror_r;
	logic [15:0] recov_pwm_r;
	logic [NCH-1:0] off_r;
	logic [NCH-1:0] flag_r;
	logic [CNT_W-1:0] recov_cnt_r [NCH];
	logic [NCH-1:0] ocr_en;
	logic [NLAMP-1:0] lamp_req;
	logic [NLAMP-1:0] lamp_nxt;
	logic [NHB-1:0] hb_high_nxt;
	logic [NHB-1:0] hb_low_nxt;
	logic [1:0] mode7;
	logic [1:0] mode8;
	logic [5:0] ref_code;
	logic src_a;
	logic src_b;
	logic pulldown_nxt;
	logic [CNT_W-1:0] recov_load;
	logic write_ok;

	ddoc_pwm_if pg ();

	ddoc_pwm_gen #(.CNT_W(DUTY_W)) u_pulse_gen
	(
		.clk(clk),
		.rst(rst),
		.duty(pulse_gen_duty),
		.pg(pg)
	);

	assign pg.enable = recov_pwm_r[PULSE_GEN_EN];
	assign write_ok = reg_wr && mode_active;

	always_ff @(posedge clk)
	begin
		if (rst || !mode_active)
			lamp_mirror_r <= LAMP_MIRROR_RESET;
		else if (write_ok && reg_addr == ADDR_LAMP_MIRROR)
			lamp_mirror_r <= reg_wdata & LAMP_MIRROR_WMASK;
	end

	always_ff @(posedge clk)
	begin
		if (rst || !mode_active)
			recov_pwm_r <= RECOV_PWM_RESET;
		else if (write_ok && reg_addr == ADDR_RECOV_PWM)
			recov_pwm_r <= reg_wdata;
	end

	// Read data lags the address by one cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= READ_ZERO;
		else if (reg_addr == ADDR_LAMP_MIRROR)
			reg_rdata <= lamp_mirror_r;
		else if (reg_addr == ADDR_RECOV_PWM)
			reg_rdata <= recov_pwm_r;
		else
			reg_rdata <= READ_ZERO;
	end

	assign ref_code = lamp_mirror_r[REF_MSB:REF_LSB];
	assign mode7 = lamp_decode(lamp_mirror_r[L7_HI], lamp_mirror_r[L7_LO]);
	assign mode8 = lamp_decode(lamp_mirror_r[L8_HI], lamp_mirror_r[L8_LO]);
	// The internal generator replaces the pins for lamps while it is enabled
	assign src_a = pg.enable ? pg.level : ext_pulse_in_a;
	assign src_b = pg.enable ? pg.level : ext_pulse_in_b;
	assign recov_load = recovery_delay_select ? CNT_W'(RECOV_LONG_CYC) : CNT_W'(RECOV_SHORT_CYC);

	always_comb
	begin
		lamp_req = {lamp_mirror_r[L11_EN], lamp_mirror_r[L10_EN], lamp_mirror_r[L9_EN], mode8[1], mode7[1]};
		lamp_req[LAMP_D] = lamp_req[LAMP_D] | lamp_mirror_r[MIRROR_EN];
		for (int i = 0; i < NLAMP; i++)
		begin
			// Lamps 7, 9, 11 follow source A; lamps 8, 10 follow source B
			lamp_nxt[i] = lamp_req[i] && !off_r[CH_LAMP0+i]
				&& pulse_gate(lamp_pwm_sel[i], (i % 2 == 0) ? src_a : src_b);
		end
		for (int i = 0; i < NHB; i++)
		begin
			ocr_en[i] = recov_pwm_r[RECOV_HB1-i];
			// Both requested counts as off, so the two switches can never overlap
			hb_high_nxt[i] = hb_high_req[i] && !hb_low_req[i] && !off_r[i]
				&& pulse_gate(recov_pwm_r[HB1_PWM_SEL-i], (i == HB_ON_PIN_B) ? ext_pulse_in_b : ext_pulse_in_a);
			hb_low_nxt[i] = hb_low_req[i] && !hb_high_req[i] && !off_r[i]
				&& pulse_gate(recov_pwm_r[HB1_PWM_SEL-i], (i == HB_ON_PIN_B) ? ext_pulse_in_b : ext_pulse_in_a);
		end
		ocr_en[CH_PD] = recov_pwm_r[RECOV_PD];
		ocr_en[NCH-1:CH_LAMP0] = lamp_ocr_en;
		pulldown_nxt = lamp_mirror_r[PD_EN] && ref_code == REF_ZERO && !off_r[CH_PD]
			&& pulse_gate(recov_pwm_r[PD_PWM], ext_pulse_in_a);
	end

	always_ff @(posedge clk)
	begin
		if (rst || !mode_active)
		begin
			lamp_on <= '0;
			lamp_high_current <= '0;
			hb_high_on <= '0;
			hb_low_on <= '0;
			mirror_feedback_pulldown_on <= 1'b0;
			mirror_pass_gate_drive <= 1'b0;
			mirror_ref_code <= REF_ZERO;
		end
		else
		begin
			lamp_on <= lamp_nxt;
			lamp_high_current <= {mode8[0] & lamp_nxt[1], mode7[0] & lamp_nxt[0]};
			hb_high_on <= hb_high_nxt;
			hb_low_on <= hb_low_nxt;
			mirror_feedback_pulldown_on <= pulldown_nxt;
			mirror_pass_gate_drive <= lamp_mirror_r[MIRROR_EN];
			mirror_ref_code <= (!recov_pwm_r[FULL_SCALE_SEL] && ref_code > REF_CLAMP) ? REF_CLAMP : ref_code;
		end
	end

	// A new event wins over a clear arriving in the same cycle
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (rst || !mode_active)
			begin
				flag_r[i] <= 1'b0;
				off_r[i] <= 1'b0;
				recov_cnt_r[i] <= '0;
			end
			else if (oc_event[i])
			begin
				flag_r[i] <= 1'b1;
				off_r[i] <= 1'b1;
				recov_cnt_r[i] <= recov_load;
			end
			else
			begin
				if (oc_flag_clear[i])
					flag_r[i] <= 1'b0;
				if (off_r[i] && ocr_en[i] && recov_cnt_r[i] != '0)
					recov_cnt_r[i] <= recov_cnt_r[i] - 1'b1;
				else if (off_r[i] && ocr_en[i])
					off_r[i] <= 1'b0;
				else if (off_r[i] && oc_flag_clear[i])
					off_r[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || !mode_active)
		begin
			output_overcurrent_flag <= '0;
			global_supply_current_fault <= 1'b0;
		end
		else
		begin
			output_overcurrent_flag <= flag_r;
			global_supply_current_fault <= |flag_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	lamp_field_decode_a: assert property (lamp_on[0] |-> $past(lamp_mirror_r[L7_HI] ^ lamp_mirror_r[L7_LO])) else $error("lamp 7 on with illegal field");
	lamp_pulse_gate_a: assert property (lamp_on[0] && $past(lamp_pwm_sel[0]) |-> $past(src_a)) else $error("lamp 7 on while source low");
	pulldown_code_a: assert property (mirror_feedback_pulldown_on |-> $past(ref_code) == REF_ZERO) else $error("pull-down on with nonzero code");
	pulldown_pulse_a: assert property (mirror_feedback_pulldown_on && $past(recov_pwm_r[PD_PWM]) |-> $past(ext_pulse_in_a)) else $error("pull-down on while pin A low");
	mirror_forces_lamp_a: assert property ($past(mode_active && lamp_mirror_r[MIRROR_EN] && !lamp_pwm_sel[LAMP_D] && !off_r[CH_LAMP0+LAMP_D]) && mode_active |-> lamp_on[LAMP_D] && mirror_pass_gate_drive) else $error("mirror enable did not force lamp 10");
	ref_clamp_a: assert property (!$past(recov_pwm_r[FULL_SCALE_SEL]) |-> mirror_ref_code <= REF_CLAMP) else $error("reference code above clamp");
	oc_shutoff_a: assert property (oc_event[CH_LAMP0] && mode_active ##1 mode_active |-> ##1 !lamp_on[0] && output_overcurrent_flag[CH_LAMP0] && global_supply_current_fault) else $error("overcurrent did not shut lamp 7");
	no_recovery_a: assert property ($fell(off_r[0]) |-> $past(ocr_en[0] && recov_cnt_r[0] == '0) || $past(oc_flag_clear[0]) || $past(!mode_active)) else $error("output released without recovery");
	hb_pin_b_a: assert property (hb_high_on[HB_ON_PIN_B] && $past(recov_pwm_r[HB1_PWM_SEL-HB_ON_PIN_B]) |-> $past(ext_pulse_in_b)) else $error("output 5 on while pin B low");
	hb_exclusive_a: assert property ((hb_high_on & hb_low_on) == '0) else $error("half-bridge shoot-through");
	standby_clear_a: assert property (!mode_active |=> lamp_mirror_r == LAMP_MIRROR_RESET && recov_pwm_r == RECOV_PWM_RESET && lamp_on == '0) else $error("standby did not clear");
	reset_zero_a: assert property (@(posedge clk) $past(rst) |-> lamp_mirror_r == LAMP_MIRROR_RESET && recov_pwm_r == RECOV_PWM_RESET) else $error("control words not zero after reset");

	lamp_pwm_c: cover property (lamp_on[0] && lamp_pwm_sel[0]);
	recovery_c: cover property ($fell(off_r[CH_LAMP0]) && ocr_en[CH_LAMP0]);
	mirror_c: cover property (mirror_pass_gate_drive && lamp_on[LAMP_D]);
endmodule

// File: ddoc_host.sv
// Host-side model: writes and addresses the control words, drives the pulse pins.
// Assumes its tasks are called from a falling-edge time step of the core clock.
`timescale 1ns/1ps
module ddoc_host
(
	input wire logic clk,
	output logic reg_wr,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic ext_pulse_in_a,
	output logic ext_pulse_in_b
);
	initial
	begin
		reg_wr = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		ext_pulse_in_a = 1'b0;
		ext_pulse_in_b = 1'b0;
	end
	// Data is inverted once the strobe drops, so a stale word is never mistaken for a write
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
		// Idle cycle so a following call never reassigns the strobe in the same time step
		@(negedge clk);
	endtask
	task automatic look(input logic [4:0] a);
		reg_addr = a;
	endtask
	task automatic pins(input logic a, input logic b);
		ext_pulse_in_a = a;
		ext_pulse_in_b = b;
	endtask
endmodule

// File: tb.sv
// Self-checking bench for the control words and output gating.
// Assumes ddoc_host stands in for the serial frame decoder; recovery delays are shortened.
`timescale 1ns/1ps
module tb;
	import ddoc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode_active = 1'b0;
	logic recovery_delay_select = 1'b0;
	logic [NHB-1:0] hb_high_req = '0;
	logic [NHB-1:0] hb_low_req = '0;
	logic [NLAMP-1:0] lamp_ocr_en = '0;
	logic [NLAMP-1:0] lamp_pwm_sel = '0;
	logic [7:0] pulse_gen_duty = 8'h00;
	logic [NCH-1:0] oc_event = '0;
	logic [NCH-1:0] oc_flag_clear = '0;
	logic reg_wr, ext_pulse_in_a, ext_pulse_in_b, mirror_pass_gate_drive, mirror_feedback_pulldown_on;
	logic global_supply_current_fault;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, w;
	logic [NHB-1:0] hb_high_on, hb_low_on;
	logic [NLAMP-1:0] lamp_on;
	logic [1:0] lamp_high_current;
	logic [5:0] mirror_ref_code, c, s;
	logic [6:0] x;
	logic [NCH-1:0] output_overcurrent_flag;
	int err_count = 0;
	int checks = 0;
	always #12.5 clk = ~clk;
	ddoc_host host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.ext_pulse_in_a(ext_pulse_in_a), .ext_pulse_in_b(ext_pulse_in_b));
	ddoc_top #(.RECOV_SHORT_US(1), .RECOV_LONG_US(2), .CNT_W(12), .DUTY_W(8)) DUT (.clk(clk), .rst(rst),
		.mode_active(mode_active), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .hb_high_req(hb_high_req), .hb_low_req(hb_low_req), .lamp_ocr_en(lamp_ocr_en),
		.lamp_pwm_sel(lamp_pwm_sel), .recovery_delay_select(recovery_delay_select),
		.ext_pulse_in_a(ext_pulse_in_a), .ext_pulse_in_b(ext_pulse_in_b), .pulse_gen_duty(pulse_gen_duty),
		.oc_event(oc_event), .oc_flag_clear(oc_flag_clear), .hb_high_on(hb_high_on), .hb_low_on(hb_low_on),
		.lamp_on(lamp_on), .lamp_high_current(lamp_high_current), .mirror_pass_gate_drive(mirror_pass_gate_drive),
		.mirror_feedback_pulldown_on(mirror_feedback_pulldown_on), .mirror_ref_code(mirror_ref_code),
		.output_overcurrent_flag(output_overcurrent_flag), .global_supply_current_fault(global_supply_current_fault));
	// Returns {high current 8..7, lamp on 11..7}
	function automatic logic [6:0] lamp_exp(input logic [15:0] v);
		lamp_exp = {v[13:12] == 2'b10, v[15:14] == 2'b10, v[L11_EN], v[L10_EN] | v[MIRROR_EN], v[L9_EN],
			^v[13:12], ^v[15:14]};
	endfunction
	function automatic logic [5:0] ref_exp(input logic [5:0] v, input logic f);
		ref_exp = (f || v <= REF_CLAMP) ? v : REF_CLAMP;
	endfunction
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#(25 * 5000);
		err_count++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(25));
		cyc(2);
		rst = 1'b0;
		mode_active = 1'b1;
		host.look(ADDR_RECOV_PWM);
		cyc(2);
		chk("word2", reg_rdata, RECOV_PWM_RESET);
		host.look(ADDR_LAMP_MIRROR);
		cyc(2);
		chk("word1", reg_rdata, LAMP_MIRROR_RESET);
		chk("lamp_on", lamp_on, 5'h00);
		$display("test reset done");
		for (int i = 0; i < 16; i++)
		begin
			w = {i[3:0], 3'($urandom), 9'h000};
			host.wr(ADDR_LAMP_MIRROR, w);
			cyc(3);
			x = lamp_exp(w);
			chk("lamp_on", lamp_on, x[4:0]);
			chk("high_current", lamp_high_current, x[6:5]);
			chk("word1", reg_rdata, w);
		end
		$display("test lamp decode done");
		// Codes 63 and 52 sit above the clamp; 63 is tried with and without full scale, 52 only without
		for (int i = 0; i < 12; i++)
		begin
			c = (i < 2) ? 6'h00 : (i == 2 || i == 3) ? 6'h3f : (i == 4) ? 6'h34 : 6'($urandom);
			w = {7'h00, (i < 4) | 1'($urandom), c, 1'($urandom), 1'b1};
			host.wr(ADDR_RECOV_PWM, {15'h0000, i[0]});
			host.wr(ADDR_LAMP_MIRROR, w);
			cyc(3);
			x = lamp_exp(w);
			chk("ref_code", mirror_ref_code, ref_exp(c, i[0]));
			chk("pulldown", mirror_feedback_pulldown_on, w[PD_EN] & (c == REF_ZERO));
			chk("pass_gate", mirror_pass_gate_drive, w[MIRROR_EN]);
			chk("lamp_on", lamp_on, x[4:0]);
			chk("word1", reg_rdata, w & LAMP_MIRROR_WMASK);
		end
		$display("test mirror done");
		for (int i = 0; i < 16; i++)
		begin
			hb_high_req = 6'($urandom);
			hb_low_req = (i < 2) ? hb_high_req : 6'($urandom);
			s = 6'($urandom);
			host.pins(1'($urandom), 1'($urandom));
			host.wr(ADDR_RECOV_PWM, {8'h00, s, 2'b00});
			cyc(3);
			chk("word2", reg_rdata, {8'h00, s, 2'b00});
			for (int k = 0; k < NHB; k++)
			begin
				x[0] = ~s[5 - k] | ((k == HB_ON_PIN_B) ? ext_pulse_in_b : ext_pulse_in_a);
				chk("hb_high", hb_high_on[k], hb_high_req[k] & ~hb_low_req[k] & x[0]);
				chk("hb_low", hb_low_on[k], hb_low_req[k] & ~hb_high_req[k] & x[0]);
			end
		end
		$display("test half bridge done");
		host.wr(ADDR_RECOV_PWM, 16'h0002);
		host.wr(ADDR_LAMP_MIRROR, 16'h4100);
		lamp_pwm_sel = 5'h01;
		for (int i = 0; i < 4; i++)
		begin
			host.pins(i[0], i[1]);
			cyc(3);
			chk("pulldown", mirror_feedback_pulldown_on, i[0]);
			chk("lamp7", lamp_on[0], i[0]);
		end
		// Internal source at zero duty must override the high pin
		host.wr(ADDR_RECOV_PWM, 16'h0100);
		cyc(3);
		chk("lamp7", lamp_on[0], 1'b0);
		// Full duty with both pins low: only the internal source can light lamp 7
		pulse_gen_duty = 8'hff;
		host.pins(1'b0, 1'b0);
		cyc(3);
		chk("lamp7", lamp_on[0], 1'b1);
		$display("test pulse gating done");
		lamp_pwm_sel = 5'h00;
		host.wr(ADDR_RECOV_PWM, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			// Pass 0 has no recovery, pass 1 the long delay, pass 2 the short one
			lamp_ocr_en = 5'(i > 0);
			recovery_delay_select = (i < 2);
			oc_event[CH_LAMP0] = 1'b1;
			cyc(1);
			oc_event = '0;
			cyc(2);
			chk("lamp7", lamp_on[0], 1'b0);
			chk("oc_flag", output_overcurrent_flag, 12'h080);
			chk("fault", global_supply_current_fault, 1'b1);
			cyc(60);
			chk("lamp7", lamp_on[0], 1'(i == 2));
			cyc(40);
			chk("lamp7", lamp_on[0], 1'(i > 0));
			oc_flag_clear = 12'h080;
			cyc(1);
			oc_flag_clear = '0;
			cyc(3);
			chk("oc_flag", output_overcurrent_flag, 12'h000);
		end
		// Event and clear in one cycle: the event must win
		oc_event[CH_PD] = 1'b1;
		oc_flag_clear[CH_PD] = 1'b1;
		cyc(1);
		oc_event = '0;
		oc_flag_clear = '0;
		cyc(2);
		chk("oc_flag", output_overcurrent_flag, 12'h040);
		chk("pulldown", mirror_feedback_pulldown_on, 1'b0);
		$display("test overcurrent done");
		mode_active = 1'b0;
		host.wr(ADDR_LAMP_MIRROR, 16'hffff);
		cyc(3);
		chk("lamp_on", lamp_on, 5'h00);
		chk("word1", reg_rdata, READ_ZERO);
		mode_active = 1'b1;
		host.look(5'h1f);
		cyc(2);
		chk("unmapped", reg_rdata, READ_ZERO);
		$display("test standby done");
		give_verdict();
	end
endmodule
